//--- pss_pkg.sv
// constants, state encoding and timing counts for the print period sequencer
// assumes a single 125 MHz engine clock and a synchronous active-high reset
// What this block does
// R1 - stay in warm-up until fuser reaches target temperature, then go to standby
// R2 - warm-up checks no jam, all toner present, image stabilization done
// R3 - standby holds until the active-low print request arrives
// R4 - after last rotations return to standby and wait for a new request
// R5 - keep regulating the fuser at target temperature during standby
// R6 - after 30 minutes in standby run the main motor for 0.5 second
// R7 - print request enters initial rotations until drum reaches top position
// R8 - in initial rotations issue print sequence command once scanner is at speed
// R9 - print period runs past each transfer until drum reaches registration position
// R10 - during print the supplied video is passed on to form the image
// R11 - last rotations deliver sheet, discharge drum, end when main motor stops
// R12 - count completed prints and start drum cleaning after every 100 prints
// R13 - drum sense falling edge means top, rising edge means registration
// R14 - print counter clears when cleaning starts and keeps value across periods
package pss_pkg;

   // engine clock
   localparam int unsigned CLK_HZ = 125_000_000;

   // standby anti-deformation turn, times in their own units
   localparam int unsigned STANDBY_IDLE_MIN = 30;
   localparam int unsigned MOTOR_TURN_MS = 500;
   localparam int unsigned IDLE_W = 38;
   localparam int unsigned TURN_W = 26;
   // least time: exact at this rate, so no rounding is lost
   localparam longint unsigned STANDBY_IDLE_CYCLES =
      64'(STANDBY_IDLE_MIN) * 64'd60 * 64'(CLK_HZ);
   // run time of the turn, rounded down
   localparam longint unsigned MOTOR_TURN_CYCLES =
      (64'(CLK_HZ) * 64'(MOTOR_TURN_MS)) / 64'd1000;

   // cleaning schedule
   localparam int unsigned CNT_W = 7;
   localparam logic [CNT_W-1:0] CLEAN_EVERY = 7'h64;
   localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;

   // video path
   localparam int unsigned VID_W = 8;
   localparam logic [VID_W-1:0] VID_IDLE = 8'h00;

   // operating periods, gray coded along warm-up to last rotations
   typedef enum logic [2:0] {
      PSS_WARMUP = 3'h0,
      PSS_STANDBY = 3'h1,
      PSS_INIT_ROT = 3'h3,
      PSS_PRINT = 3'h2,
      PSS_LAST_ROT = 3'h6
   } pss_period_t;

endpackage

//--- pss_count_if.sv
// carrier between the sequencer and its print counter
// assumes both ends share the engine clock
`timescale 1ns/1ns
interface pss_count_if;
   logic print_done;
   logic clean_start;
   logic clean_due;
   logic [pss_pkg::CNT_W-1:0] count;

   // counter end
   modport counter (
      input print_done,
      input clean_start,
      output clean_due,
      output count
   );

   // sequencer end
   modport seq (
      output print_done,
      output clean_start,
      input clean_due,
      input count
   );
endinterface

//--- pss_print_counter.sv
// completed-print counter that schedules transfer drum cleaning
// assumes print_done and clean_start are one-cycle pulses on SYS_CLK
`timescale 1ns/1ns
module pss_print_counter (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // sequencer side
   pss_count_if.counter cif
);

   // counter survives every period change, only reset or cleaning clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         cif.count <= pss_pkg::CNT_RESET;
      end else if (cif.clean_start) begin
         // a print finishing in the same cycle is still counted
         cif.count <= cif.print_done ? 7'h01 : pss_pkg::CNT_RESET; // R14
      end else if (cif.print_done && cif.count != pss_pkg::CLEAN_EVERY) begin
         cif.count <= cif.count + 7'h01; // R12
      end
   end

   // saturates at the threshold so a missed cleaning never wraps away
   assign cif.clean_due = (cif.count == pss_pkg::CLEAN_EVERY); // R12

endmodule

//--- pss_sequencer.sv
// top of the print period sequencer: five operating periods of the engine
// assumes all inputs are synchronous to SYS_CLK and RST is the power-on reset
`timescale 1ns/1ns
module pss_sequencer #(
   parameter logic [pss_pkg::IDLE_W-1:0] STANDBY_IDLE_CYCLES =
      pss_pkg::IDLE_W'(pss_pkg::STANDBY_IDLE_CYCLES),
   parameter logic [pss_pkg::TURN_W-1:0] MOTOR_TURN_CYCLES =
      pss_pkg::TURN_W'(pss_pkg::MOTOR_TURN_CYCLES)
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // warm-up checks
   input wire logic FUSER_AT_TEMP,
   input wire logic PAPER_JAM,
   input wire logic TONER_ALL_PRESENT,
   input wire logic STAB_DONE,
   // i/o controller
   input wire logic PRINT_REQUEST_N,
   input wire logic VIDEO_VALID,
   input wire logic [pss_pkg::VID_W-1:0] VIDEO_IN,
   // mechanics and sensors
   input wire logic DRUM_POSITION_SENSE,
   input wire logic SCANNER_AT_SPEED,
   input wire logic TRANSFER_DONE,
   input wire logic SHEET_DELIVERED,
   input wire logic MAIN_MOTOR_STOPPED,
   // period indication
   output logic WARMUP_PERIOD,
   output logic STANDBY_PERIOD,
   output logic INITIAL_ROTATION_PERIOD,
   output logic PRINT_PERIOD,
   output logic LAST_ROTATION_PERIOD,
   output logic READY,
   // warm-up actions
   output logic STAB_REQ,
   output logic FUSER_REGULATE,
   // mechanical controller commands
   output logic MAIN_DRIVE_MOTOR,
   output logic PRINT_SEQ_CMD,
   output logic DELIVER_SHEET,
   output logic DRUM_DISCHARGE,
   output logic DRUM_CLEAN_START,
   // image path
   output logic VIDEO_OUT_VALID,
   output logic [pss_pkg::VID_W-1:0] VIDEO_OUT,
   // print count
   output logic [pss_pkg::CNT_W-1:0] PRINT_COUNT
);

   pss_pkg::pss_period_t period;
   pss_pkg::pss_period_t next_period;
   logic drum_prev;
   logic drum_top;
   logic drum_reg;
   logic stab_ok;
   logic cmd_sent;
   logic transfer_seen;
   logic delivered;
   logic clean_done;
   logic turning;
   logic turn_start;
   logic print_req;
   logic [pss_pkg::IDLE_W-1:0] idle_cnt;
   logic [pss_pkg::TURN_W-1:0] turn_cnt;

   pss_count_if cif ();

   // periods in which the main motor must be driven for paper handling
   function automatic logic drives_motor(input pss_pkg::pss_period_t p);
      drives_motor = (p == pss_pkg::PSS_INIT_ROT) || (p == pss_pkg::PSS_PRINT);
   endfunction

   // warm-up readiness, all checks together
   function automatic logic warm_ready(input logic temp_ok, input logic jam,
                                       input logic toner, input logic stab);
      warm_ready = temp_ok && !jam && toner && stab;
   endfunction

   // print counter and cleaning schedule
   pss_print_counter u_counter (
      .clk(SYS_CLK),
      .rst(RST),
      .cif(cif)
   );

   // edges of the drum sensor; inputs are already synchronous
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         drum_prev <= 1'b1;
      end else begin
         drum_prev <= DRUM_POSITION_SENSE;
      end
   end

   assign drum_top = drum_prev && !DRUM_POSITION_SENSE; // R13
   assign drum_reg = !drum_prev && DRUM_POSITION_SENSE; // R13
   assign print_req = !PRINT_REQUEST_N;

   // image stabilization result is held until warm-up ends
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         stab_ok <= 1'b0;
      end else if (period != pss_pkg::PSS_WARMUP) begin
         stab_ok <= 1'b0;
      end else if (STAB_DONE) begin
         stab_ok <= 1'b1; // R2
      end
   end

   // period transitions
   always_comb begin
      next_period = period;
      case (period)
         pss_pkg::PSS_WARMUP: begin
            if (warm_ready(FUSER_AT_TEMP, PAPER_JAM, TONER_ALL_PRESENT, stab_ok)) begin
               next_period = pss_pkg::PSS_STANDBY; // R1 R2
            end
         end
         pss_pkg::PSS_STANDBY: begin
            if (print_req) begin
               next_period = pss_pkg::PSS_INIT_ROT; // R3 R4
            end
         end
         pss_pkg::PSS_INIT_ROT: begin
            // top edge counts only once the print sequence is under way
            if (cmd_sent && drum_top) begin
               next_period = pss_pkg::PSS_PRINT; // R7
            end
         end
         pss_pkg::PSS_PRINT: begin
            if (transfer_seen && drum_reg) begin
               next_period = pss_pkg::PSS_LAST_ROT; // R9
            end
         end
         pss_pkg::PSS_LAST_ROT: begin
            if (delivered && clean_done && MAIN_MOTOR_STOPPED) begin
               next_period = pss_pkg::PSS_STANDBY; // R11 R4
            end
         end
         default: begin
            next_period = pss_pkg::PSS_WARMUP;
         end
      endcase
   end

   // period register; reset is the power-on restart of warm-up
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         period <= pss_pkg::PSS_WARMUP; // R1
      end else begin
         period <= next_period;
      end
   end

   // print sequence command, one pulse per initial rotations period
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cmd_sent <= 1'b0;
         PRINT_SEQ_CMD <= 1'b0;
      end else begin
         PRINT_SEQ_CMD <= 1'b0;
         if (period != pss_pkg::PSS_INIT_ROT) begin
            cmd_sent <= 1'b0;
         end else if (SCANNER_AT_SPEED && !cmd_sent) begin
            cmd_sent <= 1'b1;
            PRINT_SEQ_CMD <= 1'b1; // R8
         end
      end
   end

   // a transfer must complete before registration can end printing
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         transfer_seen <= 1'b0;
      end else if (period != pss_pkg::PSS_PRINT) begin
         transfer_seen <= 1'b0;
      end else if (TRANSFER_DONE) begin
         transfer_seen <= 1'b1; // R9
      end
   end

   // sheet delivery tracking in last rotations
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         delivered <= 1'b0;
      end else if (period != pss_pkg::PSS_LAST_ROT) begin
         delivered <= 1'b0;
      end else if (SHEET_DELIVERED) begin
         delivered <= 1'b1; // R11
      end
   end

   // cleaning start: issued once in last rotations when the count is due
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         clean_done <= 1'b0;
         DRUM_CLEAN_START <= 1'b0;
      end else begin
         DRUM_CLEAN_START <= 1'b0;
         if (period != pss_pkg::PSS_LAST_ROT) begin
            clean_done <= 1'b0;
         end else if (!clean_done) begin
            clean_done <= 1'b1;
            DRUM_CLEAN_START <= cif.clean_due; // R12
         end
      end
   end

   // counter is told at the end of the print period, cleared at cleaning start
   assign cif.print_done = (period == pss_pkg::PSS_PRINT) &&
                           (next_period == pss_pkg::PSS_LAST_ROT); // R12
   assign cif.clean_start = DRUM_CLEAN_START; // R14

   // standby idle timer; restarts after each turn so long idles repeat it
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         idle_cnt <= '0;
      end else if (period != pss_pkg::PSS_STANDBY || turning) begin
         idle_cnt <= '0;
      end else if (idle_cnt != STANDBY_IDLE_CYCLES - 38'h1) begin
         idle_cnt <= idle_cnt + 38'h1;
      end else begin
         idle_cnt <= '0;
      end
   end

   assign turn_start = (period == pss_pkg::PSS_STANDBY) && !turning &&
                       (idle_cnt == STANDBY_IDLE_CYCLES - 38'h1); // R6

   // anti-deformation turn of the fuser roller
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         turning <= 1'b0;
         turn_cnt <= '0;
      end else if (turn_start) begin
         turning <= 1'b1; // R6
         turn_cnt <= '0;
      end else if (turning) begin
         // the turn still finishes if printing starts meanwhile
         if (turn_cnt == MOTOR_TURN_CYCLES - 26'h1) begin
            turning <= 1'b0; // R6
         end else begin
            turn_cnt <= turn_cnt + 26'h1;
         end
      end
   end

   // main motor demand: feeding periods, last rotations until delivery, turn
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         MAIN_DRIVE_MOTOR <= 1'b0;
      end else begin
         MAIN_DRIVE_MOTOR <= drives_motor(next_period) || turning || turn_start ||
            ((next_period == pss_pkg::PSS_LAST_ROT) && !delivered && !SHEET_DELIVERED); // R11
      end
   end

   // last rotations actions toward the mechanical controller
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         DELIVER_SHEET <= 1'b0;
         DRUM_DISCHARGE <= 1'b0;
      end else begin
         DELIVER_SHEET <= (next_period == pss_pkg::PSS_LAST_ROT) && !delivered &&
                          !SHEET_DELIVERED; // R11
         DRUM_DISCHARGE <= (next_period == pss_pkg::PSS_LAST_ROT); // R11
      end
   end

   // video path: only passes data while printing, idle value otherwise
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         VIDEO_OUT <= pss_pkg::VID_IDLE;
         VIDEO_OUT_VALID <= 1'b0;
      end else if (period == pss_pkg::PSS_PRINT && VIDEO_VALID) begin
         VIDEO_OUT <= VIDEO_IN; // R10
         VIDEO_OUT_VALID <= 1'b1; // R10
      end else begin
         VIDEO_OUT <= pss_pkg::VID_IDLE;
         VIDEO_OUT_VALID <= 1'b0;
      end
   end

   // fuser regulation and stabilization request
   // regulation stays on outside standby too, so a print never cools the roller
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         FUSER_REGULATE <= 1'b0;
         STAB_REQ <= 1'b0;
      end else begin
         FUSER_REGULATE <= 1'b1; // R5 R1
         STAB_REQ <= (next_period == pss_pkg::PSS_WARMUP) && !stab_ok && !STAB_DONE; // R2
      end
   end

   // period indication straight from the period register
   assign WARMUP_PERIOD = (period == pss_pkg::PSS_WARMUP);
   assign STANDBY_PERIOD = (period == pss_pkg::PSS_STANDBY);
   assign INITIAL_ROTATION_PERIOD = (period == pss_pkg::PSS_INIT_ROT);
   assign PRINT_PERIOD = (period == pss_pkg::PSS_PRINT);
   assign LAST_ROTATION_PERIOD = (period == pss_pkg::PSS_LAST_ROT);
   assign READY = (period == pss_pkg::PSS_STANDBY); // R5
   assign PRINT_COUNT = cif.count;

endmodule

//--- pss_sequencer_sva.sv
// concurrent checks on the ports of the print period sequencer
// assumes it is bound to pss_sequencer and shares its clock and reset
`timescale 1ns/1ns
module pss_seq_chk (
   // clock and reset
   input logic SYS_CLK,
   input logic RST,
   // inputs watched
   input logic FUSER_AT_TEMP,
   input logic PAPER_JAM,
   input logic PRINT_REQUEST_N,
   input logic VIDEO_VALID,
   input logic [pss_pkg::VID_W-1:0] VIDEO_IN,
   input logic SCANNER_AT_SPEED,
   // outputs watched
   input logic WARMUP_PERIOD,
   input logic STANDBY_PERIOD,
   input logic INITIAL_ROTATION_PERIOD,
   input logic PRINT_PERIOD,
   input logic LAST_ROTATION_PERIOD,
   input logic FUSER_REGULATE,
   input logic MAIN_DRIVE_MOTOR,
   input logic PRINT_SEQ_CMD,
   input logic DRUM_DISCHARGE,
   input logic DRUM_CLEAN_START,
   input logic VIDEO_OUT_VALID,
   input logic [pss_pkg::VID_W-1:0] VIDEO_OUT,
   input logic [pss_pkg::CNT_W-1:0] PRINT_COUNT
);
   // one clock domain, so one default for all checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   a_warmup_cold: assert property (WARMUP_PERIOD && !FUSER_AT_TEMP |=> WARMUP_PERIOD)
      else $error("left warm-up with a cold fuser");
   a_jam_blocks: assert property (WARMUP_PERIOD && PAPER_JAM |=> WARMUP_PERIOD)
      else $error("left warm-up with paper jammed");
   a_standby_wait: assert property (STANDBY_PERIOD && PRINT_REQUEST_N |=> STANDBY_PERIOD)
      else $error("left standby without a request");
   a_request_start: assert property (STANDBY_PERIOD && !PRINT_REQUEST_N
      |=> INITIAL_ROTATION_PERIOD && MAIN_DRIVE_MOTOR)
      else $error("request did not start initial rotations");
   a_fuser_held: assert property (STANDBY_PERIOD |-> FUSER_REGULATE)
      else $error("fuser not regulated in standby");
   a_cmd_cause: assert property (PRINT_SEQ_CMD
      |-> $past(INITIAL_ROTATION_PERIOD) && $past(SCANNER_AT_SPEED))
      else $error("print command without scanner at speed");
   a_video_echo: assert property (PRINT_PERIOD && VIDEO_VALID
      |=> VIDEO_OUT_VALID && VIDEO_OUT == $past(VIDEO_IN))
      else $error("video byte not passed on");
   a_video_gate: assert property (!PRINT_PERIOD |=> !VIDEO_OUT_VALID)
      else $error("video passed outside print");
   a_discharge_on: assert property (LAST_ROTATION_PERIOD |-> DRUM_DISCHARGE)
      else $error("drum not discharged in last rotations");
   a_clean_count: assert property (DRUM_CLEAN_START
      |-> PRINT_COUNT == 7'h64 ##1 PRINT_COUNT == 7'h00)
      else $error("cleaning not tied to the hundredth print");
endmodule

//--- pss_io_model.sv
// i/o controller model: print request and video stream
// assumes it shares the engine clock and reset with the sequencer
`timescale 1ns/1ns
module pss_io_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // testbench control and sequencer state
   input wire logic want_print,
   input wire logic print_period,
   // towards the sequencer
   output logic print_request_n,
   output logic video_valid,
   output logic [pss_pkg::VID_W-1:0] video
);
   // request is a level, held low as long as a job is wanted
   always_ff @(posedge clk) begin
      if (rst)
         print_request_n <= 1'b1;
      else
         print_request_n <= !want_print;
   end

   // video only in print; idle byte flips each cycle so a stale value never matches
   always_ff @(posedge clk) begin
      if (rst) begin
         video_valid <= 1'b0;
         video <= 8'h5a;
      end else begin
         video_valid <= print_period;
         video <= print_period ? video + 8'h01 : ~video;
      end
   end
endmodule

//--- tb_print_period_sequencer.sv
// self-checking bench for the print period sequencer
// assumes pss_pkg, the design and pss_io_model are compiled first
`timescale 1ns/1ns
module tb_print_period_sequencer;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fuser = 1'b0, jam = 1'b1, toner = 1'b0, stab = 1'b0, go = 1'b0;
   logic drum = 1'b1, scan = 1'b0, xfer = 1'b0, sheet = 1'b0, stopped = 1'b0;
   logic req_n, vvalid, warm, standby_period, init_p, prn_p, last_p, ready, stab_req, fuser_reg;
   logic motor, cmd, deliver, discharge, clean, vout_v;
   logic [7:0] vin, vout;
   logic [6:0] count, exp_cnt = 7'h00;
   int fails = 0, total_checks = 0, n, m;

   // short idle and turn counts keep the run small
   pss_sequencer #(.STANDBY_IDLE_CYCLES(38'h32), .MOTOR_TURN_CYCLES(26'h0a)) pss_sequencer_inst (
      .SYS_CLK(clk), .RST(rst), .FUSER_AT_TEMP(fuser), .PAPER_JAM(jam),
      .TONER_ALL_PRESENT(toner), .STAB_DONE(stab), .PRINT_REQUEST_N(req_n),
      .VIDEO_VALID(vvalid), .VIDEO_IN(vin), .DRUM_POSITION_SENSE(drum),
      .SCANNER_AT_SPEED(scan), .TRANSFER_DONE(xfer), .SHEET_DELIVERED(sheet),
      .MAIN_MOTOR_STOPPED(stopped), .WARMUP_PERIOD(warm), .STANDBY_PERIOD(standby_period),
      .INITIAL_ROTATION_PERIOD(init_p), .PRINT_PERIOD(prn_p),
      .LAST_ROTATION_PERIOD(last_p), .READY(ready), .STAB_REQ(stab_req),
      .FUSER_REGULATE(fuser_reg), .MAIN_DRIVE_MOTOR(motor), .PRINT_SEQ_CMD(cmd),
      .DELIVER_SHEET(deliver), .DRUM_DISCHARGE(discharge), .DRUM_CLEAN_START(clean),
      .VIDEO_OUT_VALID(vout_v), .VIDEO_OUT(vout), .PRINT_COUNT(count));

   pss_io_model pss_io_model_inst (.clk(clk), .rst(rst), .want_print(go),
      .print_period(prn_p), .print_request_n(req_n), .video_valid(vvalid), .video(vin));

   // 125 MHz engine clock
   always #4 clk = ~clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // drives follow at the edge, checks one step later
   task automatic step(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // request held while the warm-up checks fail must be ignored; it is dropped as the last check passes
   task automatic t_warmup();
      go <= 1'b1;
      step(6);
      fuser <= 1'b1;
      toner <= 1'b1;
      #1 check(warm, 1'b1);
      check(fuser_reg, 1'b1);
      check(stab_req, 1'b1);
      step(4);
      jam <= 1'b0;
      #1 check(warm, 1'b1);
      step(4);
      go <= 1'b0;
      stab <= 1'b1;
      #1 check(warm, 1'b1);
      step(1);
      stab <= 1'b0;
      step(3);
      #1 check(standby_period, 1'b1);
      check(ready, 1'b1);
      check(stab_req, 1'b0);
      step(3);
      #1 check(standby_period, 1'b1);
   endtask

   // long standby turns the main motor once, for the set time plus one cycle
   task automatic t_idle_turn();
      n = 0;
      m = 0;
      while (motor !== 1'b1 && n < 80) begin
         step(1);
         #1 n++;
      end
      check(n >= 38 && n <= 52, 1'b1);
      check(standby_period, 1'b1);
      while (motor === 1'b1 && m < 20) begin
         step(1);
         #1 m++;
      end
      check(8'(m), 8'h0b);
   endtask

   // one full job, with an early drum rise that must not end print
   task automatic print_job();
      logic due;
      // request raised on an edge, not one step after a check
      step(1);
      go <= 1'b1;
      step(2);
      go <= 1'b0;
      scan <= 1'b1;
      #1 check(init_p, 1'b1);
      check(motor, 1'b1);
      step(1);
      drum <= 1'b0;
      #1 check(cmd, 1'b1);
      step(1);
      #1 check(prn_p, 1'b1);
      check(cmd, 1'b0);
      step(3);
      drum <= 1'b1;
      #1 check(vout_v, 1'b1);
      check(vout, vin - 8'h01);
      step(2);
      drum <= 1'b0;
      xfer <= 1'b1;
      #1 check(prn_p, 1'b1);
      step(1);
      xfer <= 1'b0;
      drum <= 1'b1;
      step(1);
      exp_cnt = exp_cnt + 7'h01;
      due = (exp_cnt == 7'h64);
      #1 check(last_p, 1'b1);
      check(discharge, 1'b1);
      check(deliver, 1'b1);
      check(count, exp_cnt);
      step(1);
      #1 check(clean, due);
      if (due)
         exp_cnt = 7'h00;
      step(1);
      sheet <= 1'b1;
      #1 check(count, exp_cnt);
      step(1);
      sheet <= 1'b0;
      #1 check(deliver, 1'b0);
      check(motor, 1'b0);
      step(2);
      stopped <= 1'b1;
      #1 check(last_p, 1'b1);
      step(1);
      stopped <= 1'b0;
      scan <= 1'b0;
      #1 check(standby_period, 1'b1);
   endtask

   // main sequence: reset 4 cycles, then the scenarios
   initial begin
      step(4);
      rst <= 1'b0;
      t_warmup();
      t_idle_turn();
      for (int j = 0; j < 100; j++)
         print_job();
      print_verdict();
   end

   // a hang ends the run as a failure
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
endmodule

bind pss_sequencer pss_seq_chk pss_seq_chk_inst (.SYS_CLK, .RST, .FUSER_AT_TEMP, .PAPER_JAM,
   .PRINT_REQUEST_N, .VIDEO_VALID, .VIDEO_IN, .SCANNER_AT_SPEED, .WARMUP_PERIOD,
   .STANDBY_PERIOD, .INITIAL_ROTATION_PERIOD, .PRINT_PERIOD, .LAST_ROTATION_PERIOD,
   .FUSER_REGULATE, .MAIN_DRIVE_MOTOR, .PRINT_SEQ_CMD, .DRUM_DISCHARGE, .DRUM_CLEAN_START,
   .VIDEO_OUT_VALID, .VIDEO_OUT, .PRINT_COUNT);
